// *** wdl_lock_ctrl.sv ***
// Watchdog timer with keyed stop-mode setting, reload lock and reset status flags, APB slave.
`timescale 1ns/1ps
module wdl_lock_ctrl
    import wdl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic refresh,
    input wire logic stop_mode,
    input wire logic ext_reset_seen,
    input wire logic gpio_wake,
    output logic device_reset,
    output logic stop_recovery,
    output logic vector_fetch,
    output logic wdt_osc_en,
    output logic irq
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] stop_sync_reg, stop_sync_next;
    logic [1:0] ext_sync_reg, ext_sync_next;
    logic [1:0] gpio_sync_reg, gpio_sync_next;

    always_comb begin
        stop_sync_next = {stop_sync_reg[0], stop_mode};
        ext_sync_next = {ext_sync_reg[0], ext_reset_seen};
        gpio_sync_next = {gpio_sync_reg[0], gpio_wake};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_sync_reg <= 2'h0;
            ext_sync_reg <= 2'h0;
            gpio_sync_reg <= 2'h0;
        end else begin
            stop_sync_reg <= stop_sync_next;
            ext_sync_reg <= ext_sync_next;
            gpio_sync_reg <= gpio_sync_next;
        end
    end

    logic stopped;
    logic ext_lvl;
    logic gpio_lvl;
    assign stopped = stop_sync_reg[1];
    assign ext_lvl = ext_sync_reg[1];
    assign gpio_lvl = gpio_sync_reg[1];

    // ************************************************************
    // Bus decode
    // ************************************************************
    wdl_access_type acc;
    logic known;
    assign acc.sel = psel & penable;
    assign acc.wr = psel & penable & pwrite;
    assign acc.rd = psel & penable & ~pwrite;
    assign acc.addr = paddr;
    assign acc.data = pwdata[7:0];

    function automatic logic hit(input wdl_access_type a, input logic [11:0] off);
        hit = (a.addr == off);
    endfunction : hit

    assign known = hit(acc, WDL_CTL_OFFSET) | hit(acc, WDL_RLU_OFFSET) | hit(acc, WDL_RLH_OFFSET)
        | hit(acc, WDL_RLL_OFFSET) | hit(acc, WDL_CFG_OFFSET) | hit(acc, WDL_IST_OFFSET)
        | hit(acc, WDL_ICLR_OFFSET) | hit(acc, WDL_IEN_OFFSET);
    assign pready = 1'b1;
    assign pslverr = acc.sel & ~known;

    // ************************************************************
    // Key state machine and register state
    // ************************************************************
    wdl_key_type key_reg, key_next;
    logic [7:0] ctl_reg, ctl_next;
    logic [23:0] reload_reg, reload_next;
    logic [23:0] count_reg, count_next;
    logic [2:0] cfg_reg, cfg_next;
    logic en_prev_reg, en_prev_next;
    logic [WDL_IRQ_W-1:0] ist_reg, ist_next;
    logic [WDL_IRQ_W-1:0] ien_reg, ien_next;
    logic ext_prev_reg, ext_prev_next;
    logic gpio_prev_reg, gpio_prev_next;
    logic rst_reg, rst_next;
    logic rec_reg, rec_next;
    logic vec_reg, vec_next;
    logic [31:0] rdata_reg, rdata_next;

    logic wdt_run;
    logic timeout;
    logic tmo_normal;
    logic tmo_stop;
    logic gpio_rise;
    logic ext_rise;
    logic [WDL_IRQ_W-1:0] ev;
    logic rd_setup;

    assign wdt_run = cfg_reg[WDL_CFG_EN] & ~(stopped & ctl_reg[WDL_BIT_SM]);
    assign timeout = wdt_run & (count_reg == 24'h000000);
    assign tmo_normal = timeout & cfg_reg[WDL_CFG_RST] & ~stopped;
    assign tmo_stop = timeout & cfg_reg[WDL_CFG_RST] & stopped;
    assign gpio_rise = gpio_lvl & ~gpio_prev_reg & stopped;
    assign ext_rise = ext_lvl & ~ext_prev_reg;
    assign ev = {tmo_normal, tmo_stop | gpio_rise, timeout};
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        key_next = key_reg;
        ctl_next = ctl_reg;
        reload_next = reload_reg;
        cfg_next = cfg_reg;

        // A read clears the flags it returned; a code that landed after the setup edge stays to be read.
        if (acc.rd && hit(acc, WDL_CTL_OFFSET) && ctl_reg[7:4] == rdata_reg[7:4]) begin
            ctl_next[7:4] = 4'h0;
        end

        // Key writes never touch control bits except the final stop setting.
        if (acc.wr) begin
            key_next = WDL_IDLE;
            unique case (key_reg)
                WDL_IDLE: begin
                    if (hit(acc, WDL_CTL_OFFSET) && acc.data == WDL_KEY1) key_next = WDL_GOT1;
                end
                WDL_GOT1: begin
                    if (hit(acc, WDL_CTL_OFFSET) && acc.data == WDL_KEY2) key_next = WDL_GOT2;
                end
                WDL_GOT2: begin
                    if (hit(acc, WDL_CTL_OFFSET) && acc.data == WDL_STOP_OFF) begin
                        ctl_next[WDL_BIT_SM] = 1'b1;
                    end else if (hit(acc, WDL_CTL_OFFSET) && acc.data == WDL_STOP_ON) begin
                        ctl_next[WDL_BIT_SM] = 1'b0;
                    end else if (hit(acc, WDL_RLU_OFFSET)) begin
                        reload_next[23:16] = acc.data;
                        key_next = WDL_UPPER;
                    end
                end
                WDL_UPPER: begin
                    if (hit(acc, WDL_RLH_OFFSET)) begin
                        reload_next[15:8] = acc.data;
                        key_next = WDL_HIGH;
                    end
                end
                WDL_HIGH: begin
                    if (hit(acc, WDL_RLL_OFFSET)) begin
                        reload_next[7:0] = acc.data;
                    end
                end
                default: key_next = WDL_IDLE;
            endcase
            if (hit(acc, WDL_CFG_OFFSET)) cfg_next = pwdata[2:0];
        end

        // Reset-source flags; events win over a read clear in the same cycle.
        if (ext_rise) begin
            ctl_next[7:4] = 4'h1;
        end
        if (gpio_rise) begin
            ctl_next[7:4] = 4'h4;
        end
        if (tmo_normal) begin
            ctl_next[7:4] = 4'h2;
        end else if (timeout & stopped) begin
            ctl_next[7:4] = 4'h6;
        end else if (timeout) begin
            ctl_next[WDL_BIT_TMO] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= WDL_IDLE;
            ctl_reg <= WDL_CTL_RESET;
            reload_reg <= WDL_RELOAD_RESET;
            cfg_reg <= WDL_CFG_RESET;
        end else begin
            key_reg <= key_next;
            ctl_reg <= ctl_next;
            reload_reg <= reload_next;
            cfg_reg <= cfg_next;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        en_prev_next = cfg_reg[WDL_CFG_EN];
        count_next = count_reg;
        if ((cfg_reg[WDL_CFG_EN] & ~en_prev_reg) | (refresh & cfg_reg[WDL_CFG_EN])) begin
            count_next = reload_reg;
        end else if (timeout) begin
            count_next = reload_reg;
        end else if (wdt_run) begin
            count_next = count_reg - 24'h000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= WDL_RELOAD_RESET;
            en_prev_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            en_prev_reg <= en_prev_next;
        end
    end

    // ************************************************************
    // Edge detectors and event pulses
    // ************************************************************
    always_comb begin
        ext_prev_next = ext_lvl;
        gpio_prev_next = gpio_lvl;
        rst_next = tmo_normal;
        rec_next = tmo_stop | gpio_rise;
        vec_next = tmo_stop & cfg_reg[WDL_CFG_IE];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_reg <= 1'b0;
            gpio_prev_reg <= 1'b0;
            rst_reg <= 1'b0;
            rec_reg <= 1'b0;
            vec_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_prev_next;
            gpio_prev_reg <= gpio_prev_next;
            rst_reg <= rst_next;
            rec_reg <= rec_next;
            vec_reg <= vec_next;
        end
    end

    // ************************************************************
    // Interrupt status and enable
    // ************************************************************
    always_comb begin
        ien_next = ien_reg;
        ist_next = ist_reg;
        if (acc.wr && hit(acc, WDL_IEN_OFFSET)) begin
            ien_next = pwdata[WDL_IRQ_W-1:0];
        end
        if (acc.wr && hit(acc, WDL_ICLR_OFFSET)) begin
            ist_next = ist_reg & ~pwdata[WDL_IRQ_W-1:0];
        end
        // An event in the cycle of a clear sets its bit again.
        ist_next = ist_next | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_reg <= '0;
            ien_reg <= '0;
        end else begin
            ist_reg <= ist_next;
            ien_reg <= ien_next;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_setup) begin
            unique case (paddr)
                WDL_CTL_OFFSET: rdata_next = {24'h000000, ctl_reg};
                WDL_RLU_OFFSET: rdata_next = {24'h000000, count_reg[23:16]};
                WDL_RLH_OFFSET: rdata_next = {24'h000000, count_reg[15:8]};
                WDL_RLL_OFFSET: rdata_next = {24'h000000, count_reg[7:0]};
                WDL_CFG_OFFSET: rdata_next = {29'h0000000, cfg_reg};
                WDL_IST_OFFSET: rdata_next = {29'h0000000, ist_reg};
                WDL_IEN_OFFSET: rdata_next = {29'h0000000, ien_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Read data is captured at the setup edge, so it stands through the whole access phase.
    assign prdata = rdata_reg;
    assign device_reset = rst_reg;
    assign stop_recovery = rec_reg;
    assign vector_fetch = vec_reg;
    assign wdt_osc_en = wdt_run;
    assign irq = |(ist_reg & ien_reg);
endmodule : wdl_lock_ctrl

// *** wdl_pkg.sv ***
// Package with register map, field layout and shared types of the watchdog lock control block.
package wdl_pkg;
    localparam logic [11:0] WDL_CTL_OFFSET = 12'h000;
    localparam logic [11:0] WDL_RLU_OFFSET = 12'h004;
    localparam logic [11:0] WDL_RLH_OFFSET = 12'h008;
    localparam logic [11:0] WDL_RLL_OFFSET = 12'h00C;
    localparam logic [11:0] WDL_CFG_OFFSET = 12'h010;
    localparam logic [11:0] WDL_IST_OFFSET = 12'h014;
    localparam logic [11:0] WDL_ICLR_OFFSET = 12'h018;
    localparam logic [11:0] WDL_IEN_OFFSET = 12'h01C;
    localparam logic [7:0] WDL_KEY1 = 8'h55;
    localparam logic [7:0] WDL_KEY2 = 8'hAA;
    localparam logic [7:0] WDL_STOP_OFF = 8'h81;
    localparam logic [7:0] WDL_STOP_ON = 8'h00;
    localparam int WDL_BIT_POR = 7;
    localparam int WDL_BIT_STOP = 6;
    localparam int WDL_BIT_TMO = 5;
    localparam int WDL_BIT_EXT = 4;
    localparam int WDL_BIT_SM = 0;
    localparam int WDL_CFG_EN = 0;
    localparam int WDL_CFG_RST = 1;
    localparam int WDL_CFG_IE = 2;
    localparam logic [7:0] WDL_CTL_RESET = 8'h80;
    localparam logic [23:0] WDL_RELOAD_RESET = 24'hFFFFFF;
    localparam logic [2:0] WDL_CFG_RESET = 3'h2;
    // Interrupt status bits: 0 timeout, 1 stop recovery, 2 device reset request.
    localparam int WDL_IRQ_W = 3;

    typedef enum logic [2:0] {
        WDL_IDLE = 3'b000,
        WDL_GOT1 = 3'b001,
        WDL_GOT2 = 3'b011,
        WDL_UPPER = 3'b010,
        WDL_HIGH = 3'b110
    } wdl_key_type;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] data;
    } wdl_access_type;
endpackage : wdl_pkg

// *** wdl_lock_ctrl_asserts.sv ***
// Assertion checker for the watchdog lock control block.
`timescale 1ns/1ps
module wdl_lock_ctrl_asserts
    import wdl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic device_reset,
    input wire logic stop_recovery,
    input wire logic vector_fetch
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {WDL_CTL_OFFSET, WDL_RLU_OFFSET, WDL_RLH_OFFSET, WDL_RLL_OFFSET,
        WDL_CFG_OFFSET, WDL_IST_OFFSET, WDL_ICLR_OFFSET, WDL_IEN_OFFSET};
    property p_rdy; acc |-> pready; endproperty
    property p_err; acc |-> (pslverr == !hit); endproperty
    property p_urd; acc && !pwrite && !hit |-> prdata == 32'h0; endproperty
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    property p_dr; device_reset |=> !device_reset; endproperty
    property p_sr; stop_recovery |=> !stop_recovery; endproperty
    property p_ex; stop_recovery |-> !device_reset; endproperty
    property p_vf; vector_fetch |-> stop_recovery; endproperty
    a_rdy: assert property (p_rdy) else $error("access not answered");
    a_err: assert property (p_err) else $error("slave error wrong");
    a_urd: assert property (p_urd) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_dr: assert property (p_dr) else $error("reset pulse too long");
    a_sr: assert property (p_sr) else $error("recovery pulse too long");
    a_ex: assert property (p_ex) else $error("reset during recovery");
    a_vf: assert property (p_vf) else $error("vector without recovery");
    c_dr: cover property (device_reset);
    c_vf: cover property (stop_recovery && vector_fetch);
    c_err: cover property (acc && pslverr);
endmodule : wdl_lock_ctrl_asserts

bind wdl_lock_ctrl wdl_lock_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_reset(device_reset), .stop_recovery(stop_recovery), .vector_fetch(vector_fetch));

// *** test_watchdog_timer_lock_control.sv ***
// Self-checking testbench of the watchdog lock control block.
`timescale 1ns/1ps
module test_watchdog_timer_lock_control
    import wdl_pkg::*;
;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} wdl_row_type;
    wdl_row_type rows [9] = '{'{WDL_CTL_OFFSET, 32'h80, 1'h0}, '{WDL_CTL_OFFSET, 32'h0, 1'h0},
        '{WDL_RLU_OFFSET, 32'hFF, 1'h0}, '{WDL_RLH_OFFSET, 32'hFF, 1'h0}, '{WDL_RLL_OFFSET, 32'hFF, 1'h0},
        '{WDL_CFG_OFFSET, 32'h2, 1'h0}, '{WDL_IST_OFFSET, 32'h0, 1'h0}, '{WDL_IEN_OFFSET, 32'h0, 1'h0},
        '{12'h020, 32'h0, 1'h1}};
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic refresh = 1'h0, stop_mode = 1'h0, ext_reset_seen = 1'h0, gpio_wake = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, device_reset, stop_recovery, vector_fetch, wdt_osc_en, irq, vf, dr, hit;
    int fails = 0, n_checks = 0;
    always #10 pclk = ~pclk;
    wdl_lock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .refresh(refresh),
        .stop_mode(stop_mode), .ext_reset_seen(ext_reset_seen), .gpio_wake(gpio_wake), .device_reset(device_reset),
        .stop_recovery(stop_recovery), .vector_fetch(vector_fetch), .wdt_osc_en(wdt_osc_en), .irq(irq));
    task automatic print_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        se = pslverr;
        rd = prdata;
        psel <= 1'h0; penable <= 1'h0;
        if (i == 16) begin
            fails++;
            print_verdict();
        end
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd & m, e);
    endtask : rdc
    task automatic waitp(input logic sr, input int n);
        hit = 1'h0;
        for (int i = 0; i < n && !hit; i++) begin
            @(negedge pclk);
            hit = sr ? stop_recovery : device_reset;
            vf = vector_fetch;
            dr = device_reset;
        end
        @(posedge pclk);
    endtask : waitp
    task automatic keys(input logic [7:0] k3, input logic more);
        apb(1'h1, WDL_CTL_OFFSET, {24'h0, WDL_KEY1});
        apb(1'h1, WDL_CTL_OFFSET, {24'h0, WDL_KEY2});
        if (more) apb(1'h1, WDL_CTL_OFFSET, {24'h0, k3});
    endtask : keys
    task automatic negchk(input logic e);
        @(negedge pclk);
        chk(wdt_osc_en, e);
        @(posedge pclk);
    endtask : negchk
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int k = 0; k < 9; k++) begin
            rdc(rows[k].a, 32'hFFFFFFFF, rows[k].d);
            chk(se, rows[k].e);
        end
        $display("register table done");
        keys(8'h0, 1'h0);
        rdc(WDL_CTL_OFFSET, 32'hFF, 32'h0);
        apb(1'h1, WDL_RLU_OFFSET, 32'h0);
        apb(1'h1, WDL_RLH_OFFSET, 32'h0);
        apb(1'h1, WDL_RLL_OFFSET, 32'h10);
        apb(1'h1, WDL_RLL_OFFSET, 32'h01);
        apb(1'h1, WDL_CFG_OFFSET, 32'h3);
        waitp(1'h0, 10);
        chk(hit, 1'h0);
        waitp(1'h0, 30);
        chk(hit, 1'h1);
        rdc(WDL_CTL_OFFSET, 32'hFF, 32'h20);
        $display("unlock and normal timeout done");
        apb(1'h1, WDL_CTL_OFFSET, {24'h0, WDL_KEY1});
        apb(1'h1, WDL_IEN_OFFSET, 32'h0);
        apb(1'h1, WDL_CTL_OFFSET, {24'h0, WDL_KEY2});
        apb(1'h1, WDL_RLU_OFFSET, 32'h0);
        apb(1'h1, WDL_RLH_OFFSET, 32'h0);
        apb(1'h1, WDL_RLL_OFFSET, 32'h1);
        refresh <= 1'h1;
        @(posedge pclk);
        refresh <= 1'h0;
        waitp(1'h0, 10);
        chk(hit, 1'h0);
        waitp(1'h0, 30);
        chk(hit, 1'h1);
        $display("broken sequence done");
        apb(1'h1, WDL_CFG_OFFSET, 32'h0);
        stop_mode <= 1'h1;
        apb(1'h1, WDL_IEN_OFFSET, 32'h7);
        apb(1'h1, WDL_CFG_OFFSET, 32'h7);
        negchk(1'h1);
        waitp(1'h1, 40);
        chk(hit, 1'h1);
        chk(vf, 1'h1);
        chk(dr, 1'h0);
        rdc(WDL_CTL_OFFSET, 32'hF0, 32'h60);
        chk(irq, 1'h1);
        apb(1'h1, WDL_ICLR_OFFSET, 32'h7);
        chk(irq, 1'h0);
        apb(1'h1, WDL_IEN_OFFSET, 32'h0);
        waitp(1'h1, 40);
        chk(irq, 1'h0);
        $display("stop recovery done");
        keys(WDL_STOP_OFF, 1'h1);
        negchk(1'h0);
        waitp(1'h1, 40);
        chk(hit, 1'h0);
        rdc(WDL_CTL_OFFSET, 32'h01, 32'h01);
        stop_mode <= 1'h0;
        repeat (4) @(posedge pclk);
        negchk(1'h1);
        keys(WDL_STOP_ON, 1'h1);
        rdc(WDL_CTL_OFFSET, 32'h01, 32'h00);
        stop_mode <= 1'h1;
        repeat (4) @(posedge pclk);
        negchk(1'h1);
        $display("stop setting done");
        apb(1'h1, WDL_CFG_OFFSET, 32'h0);
        gpio_wake <= 1'h1;
        waitp(1'h1, 10);
        chk(hit, 1'h1);
        chk(vf, 1'h0);
        rdc(WDL_CTL_OFFSET, 32'hF0, 32'h40);
        ext_reset_seen <= 1'h1;
        repeat (4) @(posedge pclk);
        rdc(WDL_CTL_OFFSET, 32'hF0, 32'h10);
        $display("wake and external flags done");
        presetn <= 1'h0;
        ext_reset_seen <= 1'h0;
        gpio_wake <= 1'h0;
        stop_mode <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(prdata, 32'h0);
        presetn <= 1'h1;
        @(posedge pclk);
        rdc(WDL_CTL_OFFSET, 32'hFF, 32'h80);
        rdc(WDL_RLL_OFFSET, 32'hFF, 32'hFF);
        $display("mid-run reset done");
        print_verdict();
    end
endmodule : test_watchdog_timer_lock_control
